// File: tb_top.sv
// Testbench for the sequencer: APB master, front end model, burst monitor.
// Assumes shortened period, blanking and tick parameters.
`timescale 1ns/100ps
module tb_top;
	import uts_pkg::*;
	localparam int PER = 32000;
	localparam int BLK = 200;
	localparam int TCK = 2;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [ADDR_W-1:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0, prdata_o, rdv, echo_at = 32'h0000_7918;
	logic pready_o, pslverr_o, tx_burst_out_o, echo_cmp_i, cmp_enable_o, tof_pulse_o, irq_o, errv;
	logic tx_d = 1'b0, tof_d = 1'b0, cmp_d = 1'b0;
	int fail_count = 0, comparisons = 0, cyc = 0, last_edge = -100000, rises = 0, gap_bad = 0;
	int t_start = 0, t_prev = 0, t_rise = 0, t_fall = 0, t_cmp = 0, n;

	uts_tof_seq #(.PERIOD_CYC(PER), .BLANK_DLY_CYC(BLK), .TICK_CYC(TCK)) i_uts_tof_seq (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .paddr_i(paddr_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .tx_burst_out_o(tx_burst_out_o),
		.echo_cmp_i(echo_cmp_i), .cmp_enable_o(cmp_enable_o), .tof_pulse_o(tof_pulse_o),
		.irq_o(irq_o));
	uts_front_model i_uts_front_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.tx_i(tx_burst_out_o), .echo_at_i(echo_at), .echo_o(echo_cmp_i));

	always #5 clk_sys_i = ~clk_sys_i;

	////////////////////////////////////////////////////////////////////////////
	// Edge monitor on the front end outputs
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		tx_d <= tx_burst_out_o;
		tof_d <= tof_pulse_o;
		cmp_d <= cmp_enable_o;
		if (tof_pulse_o === 1'b1 && tof_d === 1'b0) t_rise <= cyc;
		if (tof_pulse_o === 1'b0 && tof_d === 1'b1) t_fall <= cyc;
		if (cmp_enable_o === 1'b1 && cmp_d === 1'b0) t_cmp <= cyc;
		// Ignore the unknown-to-zero settle while reset is still applied
		if (!reset_i && tx_burst_out_o !== tx_d) begin
			last_edge <= cyc;
			if (cyc - last_edge > 2000 && tx_burst_out_o === 1'b1) begin
				t_prev <= t_start;
				t_start <= cyc;
				rises <= 1;
			end else begin
				if (cyc - last_edge != HALF_PERIOD_CYC) gap_bad <= gap_bad + 1;
				if (tx_burst_out_o === 1'b1) rises <= rises + 1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		int k;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		for (k = 0; k < 100 && pready_o !== 1'b1; k++) @(posedge clk_sys_i);
		chk_word(pready_o, 32'h1);
		rdv = prdata_o;
		errv = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_near(input logic [31:0] got, input int exp, input int tol);
		int d;
		d = int'(got) - exp;
		comparisons++;
		if (^got === 1'bx || d > tol || d < -tol) begin
			fail_count++;
			$display("wrong value at %0t: got %0d, expected %0d", $time, got, exp);
		end
	endtask : chk_near

	task automatic report_and_stop;
		$display("comparisons %0d, fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_regs;
		logic [ADDR_W-1:0] map [7] = '{REG_CTRL, REG_STATUS, REG_TOF, REG_AVG, REG_DIST,
			REG_IRQ_STAT, REG_IRQ_MASK};
		chk_word({tx_burst_out_o, cmp_enable_o, tof_pulse_o, irq_o}, 32'h0);
		foreach (map[i]) begin
			apb(1'b0, map[i], 32'h0);
			chk_word(rdv, RESET_WORD);
			chk_word(errv, 32'h0);
		end
		apb(1'b1, 12'h01c, 32'hffff_ffff);
		chk_word(errv, 32'h1);
		apb(1'b0, 12'h01c, 32'h0);
		chk_word({rdv[30:0], errv}, 32'h1);
	endtask : t_reset_regs

	task automatic t_echo;
		apb(1'b1, REG_CTRL, 32'h1);
		for (n = 0; n < 40000 && cmp_enable_o !== 1'b1; n++) @(posedge clk_sys_i);
		chk_word(cmp_enable_o, 32'h1);
		chk_word(tof_pulse_o, 32'h1);
		for (n = 0; n < 5000 && cmp_enable_o !== 1'b0; n++) @(posedge clk_sys_i);
		chk_word(cmp_enable_o, 32'h0);
		repeat (3) @(posedge clk_sys_i);
		chk_near(rises, 12, 0);
		chk_near(gap_bad, 0, 0);
		chk_near(t_cmp - t_start, 24 * HALF_PERIOD_CYC + BLK, 5);
		chk_near(t_rise - t_start, 12 * HALF_PERIOD_CYC, 3);
		chk_near(t_fall - t_rise, 31000 - 12 * HALF_PERIOD_CYC, 8);
		apb(1'b0, REG_TOF, 32'h0);
		chk_near(rdv, (31000 - 12 * HALF_PERIOD_CYC) / TCK, 5);
		apb(1'b0, REG_STATUS, 32'h0);
		chk_word(rdv & 32'h2, 32'h0);
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk_word({rdv[30:0], irq_o}, 32'h2);
		apb(1'b1, REG_IRQ_MASK, 32'h7);
		// Mask lands on the access edge; look once it has settled
		@(posedge clk_sys_i);
		chk_word(irq_o, 32'h1);
		apb(1'b1, REG_IRQ_STAT, 32'h1);
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk_word({rdv[30:0], irq_o}, 32'h0);
	endtask : t_echo

	task automatic t_abort;
		echo_at <= 32'h0;
		for (n = 0; n < 40000 && tof_pulse_o !== 1'b1; n++) @(posedge clk_sys_i);
		chk_word(tof_pulse_o, 32'h1);
		for (n = 0; n < 40000 && tof_pulse_o !== 1'b0; n++) @(posedge clk_sys_i);
		chk_word(tof_pulse_o, 32'h0);
		repeat (5) @(posedge clk_sys_i);
		chk_near(t_start - t_prev, PER, 1);
		chk_near(t_fall - t_start, 0, 3);
		chk_word(irq_o, 32'h0);
		apb(1'b1, REG_CTRL, 32'h0);
	endtask : t_abort

	initial begin
		repeat (20) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		t_reset_regs();
		t_echo();
		t_abort();
		report_and_stop();
	end

	initial begin
		repeat (90000) @(posedge clk_sys_i);
		fail_count++;
		report_and_stop();
	end
endmodule : tb_top

// File: uts_averager.sv
// Averages a fixed number of time-of-flight counts and converts to distance.
// Assumes samples arrive as single-cycle strobes, far apart.
`timescale 1ns/100ps
module uts_averager
	import uts_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Sequencer side
	uts_seq_if.avg_mp bus
);

	localparam int unsigned SUM_W = TOF_W + AVG_SHIFT;
	localparam logic [AVG_SHIFT-1:0] N_LAST = AVG_SHIFT'(AVG_N - 1);

	logic [SUM_W-1:0] sum_q;
	logic [AVG_SHIFT-1:0] n_q;
	logic inv_q;
	logic valid_q;
	logic [TOF_W-1:0] avg_q;
	logic avg_inv_q;
	logic [DIST_W-1:0] dist_q;
	logic [SUM_W-1:0] sum_d;
	logic [TOF_W-1:0] avg_d;
	logic [TOF_W+16-1:0] prod;

	assign sum_d = sum_q + SUM_W'(bus.smp_count);
	assign avg_d = sum_d[SUM_W-1:AVG_SHIFT];
	// RULE12: half round trip times speed
	// RULE11: fixed speed constant
	assign prod = avg_d * DIST_K;
	assign bus.avg_valid = valid_q;
	assign bus.avg_count = avg_q;
	assign bus.avg_invalid = avg_inv_q;
	assign bus.distance = dist_q;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			sum_q <= '0;
			n_q <= '0;
			inv_q <= 1'b0;
			valid_q <= 1'b0;
			avg_q <= '0;
			avg_inv_q <= 1'b0;
			dist_q <= '0;
		end else begin
			valid_q <= 1'b0;
			if (bus.smp_valid) begin
				// RULE10: accumulate then average
				if (n_q == N_LAST) begin
					sum_q <= '0;
					n_q <= '0;
					inv_q <= 1'b0;
					valid_q <= 1'b1;
					avg_q <= avg_d;
					// RULE12: overflow taints average
					avg_inv_q <= inv_q | bus.smp_ovf;
					dist_q <= DIST_W'(prod >> DIST_FRAC);
				end else begin
					sum_q <= sum_d;
					n_q <= n_q + 1'b1;
					inv_q <= inv_q | bus.smp_ovf;
				end
			end
		end
	end

endmodule : uts_averager

// File: uts_burst_gen.sv
// Square-wave burst generator for the transmitter driver.
// Assumes start is a one-cycle pulse; a new start restarts a running burst.
`timescale 1ns/100ps
module uts_burst_gen
	import uts_pkg::*;
#(
	parameter int unsigned HALF_CYC = HALF_PERIOD_CYC,
	parameter int unsigned PULSES = BURST_PULSES
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Sequencer side
	uts_seq_if.burst_mp bus
);

	localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);
	localparam logic [7:0] TOG_MAX = 8'(2 * PULSES - 1);
	localparam logic [7:0] TOG_MID = 8'(PULSES);

	logic [15:0] tim_q;
	logic [7:0] tog_q;
	logic run_q;
	logic tx_q;
	logic mid_q;
	logic done_q;

	assign bus.tx = tx_q;
	assign bus.mid = mid_q;
	assign bus.done = done_q;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tim_q <= 16'h0000;
			tog_q <= 8'h00;
			run_q <= 1'b0;
			tx_q <= 1'b0;
			mid_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			mid_q <= 1'b0;
			done_q <= 1'b0;
			if (bus.start) begin
				// RULE2: burst begins
				run_q <= 1'b1;
				tim_q <= 16'h0000;
				tog_q <= 8'h00;
				tx_q <= 1'b1;
			end else if (run_q) begin
				if (tim_q == HALF_LAST) begin
					tim_q <= 16'h0000;
					// RULE9: toggle count limit
					if (tog_q < TOG_MAX) begin
						tx_q <= ~tx_q;
						tog_q <= tog_q + 8'h01;
						// RULE5: midpoint marker
						if (tog_q + 8'h01 == TOG_MID) begin
							mid_q <= 1'b1;
						end
					end else begin
						// RULE9: stop, low, clear
						run_q <= 1'b0;
						tx_q <= 1'b0;
						tog_q <= 8'h00;
						done_q <= 1'b1;
					end
				end else begin
					tim_q <= tim_q + 16'h0001;
				end
			end
		end
	end

endmodule : uts_burst_gen

// File: uts_front_model.sv
// Transmitter and echo comparator front end model.
// Assumes tx_i is the sequencer's transmit output on the same clock.
`timescale 1ns/100ps
module uts_front_model (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Transducer side
	input wire logic tx_i,
	input wire logic [31:0] echo_at_i,
	output logic echo_o
);
	logic tx_prev_q;
	int t_q;
	// Time since the first rise of a burst
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tx_prev_q <= 1'b0;
			t_q <= 100000;
		end else begin
			tx_prev_q <= tx_i;
			if (tx_i && !tx_prev_q && t_q > 29000) begin
				t_q <= 0;
			end else if (t_q < 100000) begin
				t_q <= t_q + 1;
			end
		end
	end
	// echo after the set round trip
	assign echo_o = (t_q < 30100 && t_q[6]) || (echo_at_i != 0 && t_q >= echo_at_i
		&& t_q < echo_at_i + 64);
endmodule : uts_front_model

// File: uts_pkg.sv
// Constants shared by the ultrasonic time-of-flight sequencer files.
// Assumes a single 100 MHz system clock; all times become cycle counts here.
package uts_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
	// 204.8 ms between cycle starts, held in microseconds
	localparam int unsigned CYCLE_PERIOD_US = 204_800;
	localparam int unsigned CYCLE_PERIOD_CYC = CYCLE_PERIOD_US * CLK_PER_US;
	localparam int unsigned TX_FREQ_HZ = 40_000;
	localparam int unsigned HALF_PERIOD_CYC = CLK_HZ / (2 * TX_FREQ_HZ);
	localparam int unsigned BURST_PULSES = 12;
	// Ringing time; blanking is one cycle longer so it strictly exceeds it
	localparam int unsigned RING_US = 1_000;
	localparam int unsigned BLANK_CYC = RING_US * CLK_PER_US + 1;
	// Resolution of one time-of-flight count
	localparam int unsigned TOF_TICK_NS = 1_000;
	localparam int unsigned TOF_TICK_CYC = TOF_TICK_NS * CLK_PER_US / 1_000;
	localparam int unsigned TOF_W = 16;

	////////////////////////////////////////////////////////////////////////////
	// Averaging and distance
	localparam int unsigned AVG_N = 32;
	localparam int unsigned AVG_SHIFT = 5;
	// 346.13 m/s held in mm/s
	localparam longint unsigned SPEED_MM_PER_S = 346_130;
	localparam int unsigned DIST_FRAC = 16;
	// mm per count, halved for the round trip, scaled by 2^DIST_FRAC
	localparam longint unsigned DIST_K_L =
		(SPEED_MM_PER_S * TOF_TICK_NS * (64'd1 << DIST_FRAC)) / (2 * 64'd1_000_000_000);
	localparam logic [15:0] DIST_K = DIST_K_L[15:0];
	localparam int unsigned DIST_W = 32;

	////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_TOF = 12'h008;
	localparam logic [11:0] REG_AVG = 12'h00c;
	localparam logic [11:0] REG_DIST = 12'h010;
	localparam logic [11:0] REG_IRQ_STAT = 12'h014;
	localparam logic [11:0] REG_IRQ_MASK = 12'h018;
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_TOF_OVF = 1;
	localparam int unsigned ST_AVG_INV = 2;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_OVF = 1;
	localparam int unsigned IRQ_AVG = 2;
	localparam int unsigned IRQ_W = 3;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_BURST,
		SEQ_BLANK,
		SEQ_LISTEN
	} uts_state_t;

endpackage : uts_pkg

// File: uts_seq_if.sv
// Carrier between the sequencer top and its burst and averaging modules.
// Assumes all three sit on the same clock.
`timescale 1ns/100ps
interface uts_seq_if;
	import uts_pkg::*;
	logic start;
	logic mid;
	logic done;
	logic tx;
	logic smp_valid;
	logic [TOF_W-1:0] smp_count;
	logic smp_ovf;
	logic avg_valid;
	logic [TOF_W-1:0] avg_count;
	logic avg_invalid;
	logic [DIST_W-1:0] distance;

	modport burst_mp (input start, output mid, output done, output tx);
	modport avg_mp (input smp_valid, input smp_count, input smp_ovf,
		output avg_valid, output avg_count, output avg_invalid, output distance);
	modport top_mp (output start, input mid, input done, input tx,
		output smp_valid, output smp_count, output smp_ovf,
		input avg_valid, input avg_count, input avg_invalid, input distance);
endinterface : uts_seq_if

// File: uts_tof_seq.sv
// Ultrasonic time-of-flight sequencer top: cycle timer, blanking, echo
// capture, APB register slave and interrupt.
// Assumes an APB master on clk_sys_i and an asynchronous echo comparator.
//
// Behaviour
// RULE1: With run set, a new measurement cycle starts every 204.8 ms.
// RULE2: Each cycle opens with a transmit burst of twelve 40 kHz periods.
// RULE3: The comparator stays disabled for a blanking delay over 1 ms after the burst.
// RULE4: The directly coupled burst is ignored; only the later echo is measured.
// RULE5: At half the burst toggles the pulse output rises and the counter starts; start clears it.
// RULE6: The first comparator event disables it, stops and captures the count, signals done.
// RULE7: Counter overflow before an echo stops it, disables the comparator and flags invalid.
// RULE8: The pulse output width equals the measured round-trip interval.
// RULE9: The burst makes twice-pulses-minus-one toggles, then stops low and clears its count.
// RULE10: Thirty-two counts are accumulated and averaged before a distance is given.
// RULE11: Distance uses a speed of sound of 346.13 m/s.
// RULE12: Distance is half the averaged interval times the speed; overflow marks it invalid.
`timescale 1ns/100ps
module uts_tof_seq
	import uts_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = CYCLE_PERIOD_CYC,
	parameter int unsigned BLANK_DLY_CYC = BLANK_CYC,
	parameter int unsigned TICK_CYC = TOF_TICK_CYC
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// APB slave
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Transducer front end
	output logic tx_burst_out_o,
	input wire logic echo_cmp_i,
	output logic cmp_enable_o,
	output logic tof_pulse_o,
	// Interrupt
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	localparam logic [24:0] PERIOD_LAST = 25'(PERIOD_CYC - 1);
	localparam logic [19:0] BLANK_LAST = 20'(BLANK_DLY_CYC - 1);
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
	localparam logic [TOF_W-1:0] TOF_MAX = '1;

	uts_seq_if seq ();

	uts_state_t state_q;
	logic run_q;
	logic [24:0] per_q;
	logic [19:0] blank_q;
	logic [11:0] tick_q;
	logic [TOF_W-1:0] tof_q;
	logic tof_run_q;
	logic [TOF_W-1:0] tof_last_q;
	logic ovf_q;
	logic echo_s1_q;
	logic echo_s2_q;
	logic echo_s3_q;
	logic smp_valid_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic cycle_start;
	logic tof_tick;
	logic echo_evt;
	logic ovf_evt;
	logic setup;
	logic wr_acc;
	logic [IRQ_W-1:0] irq_set;

	////////////////////////////////////////////////////////////////////////////
	// Submodules
	uts_burst_gen #(
		.HALF_CYC(HALF_PERIOD_CYC),
		.PULSES(BURST_PULSES)
	) u_burst (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.bus(seq.burst_mp)
	);

	uts_averager u_avg (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.bus(seq.avg_mp)
	);

	assign seq.start = cycle_start;
	assign seq.smp_valid = smp_valid_q;
	assign seq.smp_count = tof_last_q;
	assign seq.smp_ovf = ovf_q;

	////////////////////////////////////////////////////////////////////////////
	// Echo comparator synchroniser
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			echo_s1_q <= 1'b0;
			echo_s2_q <= 1'b0;
			echo_s3_q <= 1'b0;
		end else begin
			echo_s1_q <= echo_cmp_i;
			echo_s2_q <= echo_s1_q;
			echo_s3_q <= echo_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Cycle timer
	// RULE1: periodic cycle start
	assign cycle_start = run_q && (per_q == 25'h0000000);

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			per_q <= 25'h0000000;
		end else if (!run_q || per_q == PERIOD_LAST) begin
			per_q <= 25'h0000000;
		end else begin
			per_q <= per_q + 25'h0000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Time-of-flight counter
	assign tof_tick = tof_run_q && (tick_q == TICK_LAST);
	// RULE4: only a rising comparator edge after blanking
	assign echo_evt = (state_q == SEQ_LISTEN) && echo_s2_q && !echo_s3_q;
	// Echo wins over an overflow on the same tick
	assign ovf_evt = tof_tick && (tof_q == TOF_MAX) && !echo_evt;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tof_run_q <= 1'b0;
			tof_q <= '0;
			tick_q <= 12'h000;
		end else if (cycle_start) begin
			// RULE5: pulse cleared at cycle start
			tof_run_q <= 1'b0;
			tof_q <= '0;
			tick_q <= 12'h000;
		end else if (seq.mid) begin
			// RULE5: start at burst midpoint
			tof_run_q <= 1'b1;
			tof_q <= '0;
			tick_q <= 12'h000;
		end else if (echo_evt || ovf_evt) begin
			// RULE6: stop on echo
			// RULE7: stop on overflow
			tof_run_q <= 1'b0;
		end else if (tof_run_q) begin
			if (tof_tick) begin
				tick_q <= 12'h000;
				tof_q <= tof_q + 1'b1;
			end else begin
				tick_q <= tick_q + 12'h001;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tof_last_q <= '0;
			ovf_q <= 1'b0;
			smp_valid_q <= 1'b0;
		end else begin
			smp_valid_q <= echo_evt || ovf_evt;
			if (echo_evt) begin
				// RULE6: capture the count
				tof_last_q <= tof_q;
				ovf_q <= 1'b0;
			end else if (ovf_evt) begin
				// RULE7: mark count invalid
				tof_last_q <= tof_q;
				ovf_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= SEQ_IDLE;
			blank_q <= 20'h00000;
		end else if (cycle_start) begin
			state_q <= SEQ_BURST;
			blank_q <= 20'h00000;
		end else if (ovf_evt) begin
			// RULE7: comparator off on overflow
			state_q <= SEQ_IDLE;
		end else begin
			case (state_q)
				SEQ_BURST: begin
					if (seq.done) begin
						state_q <= SEQ_BLANK;
					end
				end
				SEQ_BLANK: begin
					// RULE3: blanking over ringing
					if (blank_q == BLANK_LAST) begin
						state_q <= SEQ_LISTEN;
					end else begin
						blank_q <= blank_q + 20'h00001;
					end
				end
				SEQ_LISTEN: begin
					// RULE6: comparator off after first echo
					if (echo_evt) begin
						state_q <= SEQ_IDLE;
					end
				end
				default: begin
					state_q <= SEQ_IDLE;
				end
			endcase
		end
	end

	// RULE3: comparator enabled only when listening
	assign cmp_enable_o = (state_q == SEQ_LISTEN);
	// RULE8: pulse spans the counted interval
	assign tof_pulse_o = tof_run_q;
	assign tx_burst_out_o = seq.tx;

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in the setup cycle
	assign setup = psel_i && !penable_i;
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign pready_o = 1'b1;
	assign prdata_o = prdata_q;
	assign pslverr_o = pslverr_q;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return a == REG_CTRL || a == REG_STATUS || a == REG_TOF || a == REG_AVG
			|| a == REG_DIST || a == REG_IRQ_STAT || a == REG_IRQ_MASK;
	endfunction : is_mapped

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_q <= RESET_WORD;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			pslverr_q <= !is_mapped(paddr_i);
			prdata_q <= RESET_WORD;
			if (!pwrite_i) begin
				case (paddr_i)
					REG_CTRL: prdata_q[CTRL_RUN] <= run_q;
					REG_STATUS: begin
						prdata_q[ST_BUSY] <= (state_q != SEQ_IDLE) || tof_run_q;
						prdata_q[ST_TOF_OVF] <= ovf_q;
						prdata_q[ST_AVG_INV] <= seq.avg_invalid;
					end
					REG_TOF: prdata_q[TOF_W-1:0] <= tof_last_q;
					REG_AVG: prdata_q[TOF_W-1:0] <= seq.avg_count;
					REG_DIST: prdata_q <= seq.distance;
					REG_IRQ_STAT: prdata_q[IRQ_W-1:0] <= irq_stat_q;
					REG_IRQ_MASK: prdata_q[IRQ_W-1:0] <= irq_mask_q;
					default: prdata_q <= RESET_WORD;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			run_q <= 1'b0;
			irq_mask_q <= '0;
		end else if (wr_acc) begin
			if (paddr_i == REG_CTRL) begin
				run_q <= pwdata_i[CTRL_RUN];
			end
			if (paddr_i == REG_IRQ_MASK) begin
				irq_mask_q <= pwdata_i[IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status: write one to clear, a new event wins
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_DONE] = echo_evt;
		irq_set[IRQ_OVF] = ovf_evt;
		irq_set[IRQ_AVG] = seq.avg_valid;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_stat_q <= '0;
		end else if (wr_acc && paddr_i == REG_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~pwdata_i[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule : uts_tof_seq

// File: uts_tof_seq_assertions.sv
// Port-level checker for the time-of-flight sequencer top.
// Assumes it is bound onto uts_tof_seq; one clock, async reset.
`timescale 1ns/100ps
module uts_tof_seq_assertions
	import uts_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = CYCLE_PERIOD_CYC,
	parameter int unsigned BLANK_DLY_CYC = BLANK_CYC,
	parameter int unsigned TICK_CYC = TOF_TICK_CYC
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// APB
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Front end and interrupt
	input wire logic tx_burst_out_o,
	input wire logic echo_cmp_i,
	input wire logic cmp_enable_o,
	input wire logic tof_pulse_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	////////////////////////////////////////////////////////////////////////////
	// Cycles since the last transmit edge; saturates so a cold start looks quiet
	logic tx_prev_q;
	logic [17:0] quiet_q;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tx_prev_q <= 1'b0;
			quiet_q <= 18'h3ffff;
		end else begin
			tx_prev_q <= tx_burst_out_o;
			if (tx_burst_out_o != tx_prev_q) begin
				quiet_q <= 18'h00000;
			end else if (quiet_q != 18'h3ffff) begin
				quiet_q <= quiet_q + 18'h00001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_ready_high: assert property (pready_o) else $error("pready low");
	a_slverr_bad: assert property (psel_i && penable_i && paddr_i > 12'h018 |-> pslverr_o)
		else $error("unmapped access without error");
	a_slverr_ok: assert property (psel_i && penable_i && paddr_i <= 12'h018
		&& paddr_i[1:0] == 2'h0 |-> !pslverr_o) else $error("mapped access flagged");
	a_tx_half: assert property ($changed(tx_burst_out_o) && quiet_q < 18'h007d0
		|-> quiet_q == HALF_PERIOD_CYC - 1) else $error("burst half period wrong");
	a_cmp_burst: assert property ($changed(tx_burst_out_o) |-> !cmp_enable_o)
		else $error("comparator on during burst");
	a_cmp_blank: assert property ($rose(cmp_enable_o) |->
		quiet_q >= HALF_PERIOD_CYC + BLANK_DLY_CYC - 4 && quiet_q <= HALF_PERIOD_CYC + BLANK_DLY_CYC + 4)
		else $error("blanking length wrong");
	a_tof_mid: assert property ($rose(tof_pulse_o) |-> quiet_q <= 18'h00003)
		else $error("pulse not at burst toggle");
	a_tof_clear: assert property ($rose(tx_burst_out_o) && quiet_q > 18'h007d0
		|-> ##[0:2] !tof_pulse_o) else $error("pulse not cleared at start");
	a_echo_stop: assert property (cmp_enable_o && $rose(echo_cmp_i)
		|-> ##[1:6] (!cmp_enable_o && !tof_pulse_o)) else $error("echo did not stop count");
	a_listen_pulse: assert property (cmp_enable_o |-> tof_pulse_o)
		else $error("listening without pulse");

	c_listen: cover property ($rose(cmp_enable_o));
	c_echo: cover property (cmp_enable_o && $rose(echo_cmp_i));
	c_slverr: cover property (psel_i && penable_i && pslverr_o);
endmodule : uts_tof_seq_assertions

bind uts_tof_seq uts_tof_seq_assertions #(.PERIOD_CYC(PERIOD_CYC), .BLANK_DLY_CYC(BLANK_DLY_CYC),
	.TICK_CYC(TICK_CYC)) i_uts_tof_seq_assertions (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.tx_burst_out_o(tx_burst_out_o), .echo_cmp_i(echo_cmp_i), .cmp_enable_o(cmp_enable_o),
	.tof_pulse_o(tof_pulse_o), .irq_o(irq_o));
